// file: bench/smc_bus_peer.sv
/*
 Other parties on the open-drain bus: pull-ups, a slave that stretches
 each low phase, and a foreign master steered by the bench.
*/
`timescale 1ns/1ns
module smc_bus_peer (
   input wire logic i_clock,
   input wire logic i_scl_oe_n,
   input wire logic i_sda_oe_n,
   input wire logic i_scl_pull,
   input wire logic i_sda_pull,
   input wire logic [7:0] i_stretch,
   output logic o_scl,
   output logic o_sda
);
   logic [7:0] hold_r = 8'h00;
   logic scl_q_r = 1'b1;
   // Pull-ups: released lines read high, any low driver wins
   assign o_scl = i_scl_oe_n & ~i_scl_pull & (hold_r == 8'h00);
   assign o_sda = i_sda_oe_n & ~i_sda_pull;
   always_ff @(posedge i_clock) begin
      scl_q_r <= o_scl;
      if (scl_q_r && !o_scl && i_stretch != 8'h00) begin
         hold_r <= i_stretch;
      end else if (hold_r != 8'h00) begin
         hold_r <= hold_r - 8'h01;
      end
   end
endmodule

// file: bench/smc_timing_chk.sv
/*
 Concurrent checks on the ports of the serial bus timing core.
 Assumes single clock, sync active-low reset, config tracked from writes.
*/
`timescale 1ns/1ns
module smc_timing_chk
   import smc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic o_avs_waitrequest,
   input wire logic [3:0] i_ovf,
   input wire logic i_tmo_split,
   input wire logic o_tmo_reload_hi,
   input wire logic o_tmo_reload_lo,
   input wire logic o_tmo_count_en,
   input wire logic i_scl_in,
   input wire logic o_scl_oe_n,
   input wire logic i_sda_in,
   input wire logic o_sda_oe_n,
   input wire logic o_iface_enable,
   input wire logic o_busy
);
   logic [7:0] cfg_r;
   logic [3:0] hi_ovf_r;
   logic [3:0] lo_ovf_r;
   logic [4:0] lo_cnt_r;
   logic [4:0] sda_st_r;
   logic sda_q_r;
   wire cfg_wr = i_avs_write & ~o_avs_waitrequest
      & (i_avs_address[9:2] == SMC_CFG_IDX);
   wire tick = i_ovf[cfg_r[1:0]];
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         cfg_r <= 8'h00;
         hi_ovf_r <= 4'h0;
         lo_ovf_r <= 4'h0;
         lo_cnt_r <= 5'h00;
         sda_st_r <= 5'h00;
         sda_q_r <= 1'b1;
      end else begin
         if (cfg_wr) cfg_r <= i_avs_writedata[7:0];
         // Saturating, so long idle spans cannot wrap
         hi_ovf_r <= !o_scl_oe_n ? 4'h0 : hi_ovf_r + {3'h0, tick & ~&hi_ovf_r};
         lo_ovf_r <= o_scl_oe_n ? 4'h0 : lo_ovf_r + {3'h0, tick & ~&lo_ovf_r};
         lo_cnt_r <= o_scl_oe_n ? 5'h00 : lo_cnt_r + {4'h0, ~&lo_cnt_r};
         sda_q_r <= o_sda_oe_n;
         sda_st_r <= (o_sda_oe_n != sda_q_r) ? 5'h00
            : sda_st_r + {4'h0, ~&sda_st_r};
      end
   end
   wire ext = cfg_r[SMC_EXTH_BIT];
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   ////////////////////////////////////////////////////////////////////////
   property p_tmo_excl;
      o_tmo_count_en |-> !o_tmo_reload_hi && o_iface_enable;
   endproperty
   a_tmo_excl: assert property (p_tmo_excl)
      else $error("timer count and reload overlap");
   property p_split;
      o_tmo_reload_hi |-> (o_tmo_reload_lo == !i_tmo_split);
   endproperty
   a_split: assert property (p_split)
      else $error("low byte reload wrong for split mode");
   property p_off;
      !o_iface_enable |-> o_scl_oe_n && o_sda_oe_n && !o_tmo_count_en;
   endproperty
   a_off: assert property (p_off)
      else $error("disabled interface drives lines");
   property p_low_min;
      $rose(o_scl_oe_n) |-> lo_ovf_r >= 4'h1;
   endproperty
   a_low_min: assert property (p_low_min)
      else $error("low phase under one overflow");
   property p_high_min;
      $fell(o_scl_oe_n) |-> hi_ovf_r >= 4'h2;
   endproperty
   a_high_min: assert property (p_high_min)
      else $error("high phase under two overflows");
   property p_hold_std;
      $changed(o_sda_oe_n) && !o_scl_oe_n && !ext |-> lo_cnt_r >= 5'h02;
   endproperty
   a_hold_std: assert property (p_hold_std)
      else $error("data hold too short");
   property p_hold_ext;
      $changed(o_sda_oe_n) && !o_scl_oe_n && ext |-> lo_cnt_r >= 5'h0B;
   endproperty
   a_hold_ext: assert property (p_hold_ext)
      else $error("extended data hold too short");
   property p_setup_ext;
      $rose(o_scl_oe_n) && ext |-> sda_st_r >= 5'h09;
   endproperty
   a_setup_ext: assert property (p_setup_ext)
      else $error("extended data setup too short");
   property p_busy_set;
      $fell(i_sda_in) && i_scl_in && o_iface_enable |-> ##[1:6] o_busy;
   endproperty
   a_busy_set: assert property (p_busy_set)
      else $error("busy not set after start");
   property p_busy_clr;
      $rose(i_sda_in) && i_scl_in && o_busy |-> ##[1:6] !o_busy;
   endproperty
   a_busy_clr: assert property (p_busy_clr)
      else $error("busy not cleared after stop");
endmodule
bind smc_timing smc_timing_chk smc_timing_chk_inst (.i_clock, .i_reset_n,
   .i_avs_address, .i_avs_write, .i_avs_writedata, .o_avs_waitrequest,
   .i_ovf, .i_tmo_split, .o_tmo_reload_hi, .o_tmo_reload_lo,
   .o_tmo_count_en, .i_scl_in, .o_scl_oe_n, .i_sda_in, .o_sda_oe_n,
   .o_iface_enable, .o_busy);

// file: bench/smc_timing_tb.sv
/*
 Self-checking bench of the timing core: registers, master bits on
 each clock source, stretching, slave inhibit, free timeout, restart.
 Assumes the bus peer model and the bound checker.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
   $display("mismatch at %0t: got %h want %h", $time, (a), (e)); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 2000) begin \
   @(posedge clk); n++; end if (n >= 2000) `CHK(1'b0, 1'b1) end
module smc_timing_tb;
   import smc_pkg::*;
   localparam int P = 20;
   logic clk;
   logic rst_n = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic split = 1'b0;
   logic scl_pull = 1'b0;
   logic sda_pull = 1'b0;
   logic [9:0] addr = 10'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] ovf = 4'h0;
   logic [7:0] stretch = 8'h00;
   logic [1:0] cs = 2'h0;
   logic [7:0] q;
   logic [7:0] v;
   logic [31:0] rdata;
   logic waitr, rlh, rll, cnt, scl_oe_n, sda_oe_n, en, slave_inhibit, busy, irq;
   logic scl, sda;
   int n, ocnt, mismatches, tests_run, rnd, i;
   time t_hi;
   smc_timing smc_timing_inst (.i_clock(clk), .i_reset_n(rst_n),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdata), .o_avs_readdata(rdata),
      .o_avs_waitrequest(waitr), .i_ovf(ovf), .i_tmo_split(split),
      .o_tmo_reload_hi(rlh), .o_tmo_reload_lo(rll), .o_tmo_count_en(cnt),
      .i_scl_in(scl), .o_scl_out(), .o_scl_oe_n(scl_oe_n), .i_sda_in(sda),
      .o_sda_out(), .o_sda_oe_n(sda_oe_n), .o_iface_enable(en),
      .o_slave_inhibit(slave_inhibit), .o_busy(busy), .o_irq(irq));
   smc_bus_peer smc_bus_peer_inst (.i_clock(clk), .i_scl_oe_n(scl_oe_n),
      .i_sda_oe_n(sda_oe_n), .i_scl_pull(scl_pull), .i_sda_pull(sda_pull),
      .i_stretch(stretch), .o_scl(scl), .o_sda(sda));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Unselected sources pulse fast, so a wrong select shows in timing
   always @(posedge clk) begin
      ocnt <= (ocnt == P - 1) ? 0 : ocnt + 1;
      ovf <= (ocnt[0] ? ~(4'h1 << cs) : 4'h0)
         | ((ocnt == 0) ? (4'h1 << cs) : 4'h0);
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic bus(input logic w, input logic [7:0] idx,
         input logic [7:0] d);
      addr <= {idx, 2'b00};
      rd <= !w;
      wr <= w;
      wdata <= {24'h000000, d};
      @(posedge clk);
      // No cycle count assumed; only the watchdog ends a hang
      while (waitr !== 1'b0) begin
         @(posedge clk);
      end
      q = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      if (!w) `CHK(rdata[31:8], 24'h000000)
      @(posedge clk);
   endtask
   // Foreign master at a 320 ns link clock, still outside the frame
   task automatic frame(input logic stop);
      sda_pull <= 1'b1;
      repeat (4) @(posedge clk);
      repeat (3) begin
         scl_pull <= 1'b1;
         repeat (4) @(posedge clk);
         scl_pull <= 1'b0;
         repeat (4) @(posedge clk);
      end
      scl_pull <= 1'b1;
      sda_pull <= stop;
      repeat (4) @(posedge clk);
      scl_pull <= 1'b0;
      repeat (4) @(posedge clk);
      sda_pull <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task automatic conclude();
      $display("counts: %0d compared, %0d mismatched", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #400000;
      mismatches++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rnd = $urandom(32'h7a80);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, SMC_CFG_IDX, 8'h00); `CHK(q, SMC_CFG_RST)
      bus(1'b0, 8'h20, 8'h00); `CHK(q, 8'h00)
      for (i = 0; i < 4; i++) begin
         v = 8'($urandom);
         bus(1'b1, SMC_CFG_IDX, v);
         bus(1'b0, SMC_CFG_IDX, 8'h00); `CHK(q, v & 8'hDF)
      end
      bus(1'b1, 8'h20, 8'hFF);
      bus(1'b0, SMC_CFG_IDX, 8'h00); `CHK(q, v & 8'hDF)
      $display("test registers done");
      for (i = 0; i < 4; i++) begin
         cs <= i[1:0];
         split <= 1'($urandom);
         stretch <= (i == 3) ? 8'd30 : 8'd0;
         bus(1'b1, SMC_CFG_IDX, {3'h4, i == 1, 2'h2, i[1:0]});
         bus(1'b1, SMC_MASK_IDX, 8'h01);
         `CHK(rlh, 1'b1)
         `CHK(rll, !split)
         bus(1'b1, SMC_CTRL_IDX, 8'h05);
         `WAITC(scl === 1'b0)
         repeat (4) @(posedge clk);
         `CHK(cnt, 1'b1)
         `CHK(busy, 1'b1)
         bus(1'b1, SMC_CTRL_IDX, {5'h01, i[0], 2'h0});
         `WAITC(scl === 1'b1)
         `WAITC(scl === 1'b0)
         `CHK(n > P && n <= 2 * P + 6, 1'b1)
         if (i == 3) `CHK(n > P, 1'b1)
         `WAITC(irq === 1'b1)
         bus(1'b0, SMC_STAT_IDX, 8'h00); `CHK(q, 8'h01)
         `CHK(irq, 1'b0)
         bus(1'b1, SMC_CTRL_IDX, 8'h0E);
         `WAITC(busy === 1'b0)
         `CHK(scl & sda, 1'b1)
         $display("test master bit on source %0d done", i);
      end
      stretch <= 8'd0;
      cs <= 2'h0;
      bus(1'b1, SMC_CFG_IDX, 8'hC0);
      frame(1'b1);
      bus(1'b0, SMC_STAT_IDX, 8'h00);
      frame(1'b1);
      bus(1'b0, SMC_STAT_IDX, 8'h00); `CHK(q & 8'h06, 8'h00)
      `CHK(slave_inhibit, 1'b1)
      bus(1'b1, SMC_CFG_IDX, 8'h84);
      bus(1'b1, SMC_MASK_IDX, 8'h08);
      frame(1'b1);
      `CHK(irq, 1'b0)
      bus(1'b0, SMC_STAT_IDX, 8'h00); `CHK(q, 8'h06)
      `CHK(busy, 1'b0)
      $display("test slave inhibit done");
      frame(1'b0);
      t_hi = $time - 12 * 40;
      `CHK(busy, 1'b1)
      bus(1'b1, SMC_CTRL_IDX, 8'h05);
      `WAITC(busy === 1'b0)
      n = int'(($time - t_hi) / 40);
      `CHK(n > 10 * P && n <= 11 * P + 8, 1'b1)
      `CHK(irq, 1'b1)
      `WAITC(sda_oe_n === 1'b0)
      `CHK(n <= 4, 1'b1)
      bus(1'b0, SMC_STAT_IDX, 8'h00); `CHK(q, 8'h0A)
      bus(1'b1, SMC_CFG_IDX, 8'h00);
      // Busy drops one cycle after the enable bit does
      @(posedge clk);
      `CHK(sda_oe_n, 1'b1)
      `CHK(busy, 1'b0)
      bus(1'b0, SMC_STAT_IDX, 8'h00);
      frame(1'b1);
      bus(1'b0, SMC_STAT_IDX, 8'h00); `CHK(q, 8'h00)
      bus(1'b1, SMC_CFG_IDX, 8'h80);
      `CHK(en, 1'b1)
      $display("test free timeout and restart done");
      conclude();
   end
endmodule

// file: common/smc_line_if.sv
/*
 Sampled bus levels and bus conditions passed from the line monitor
 to the timing core.
 Assumes both ends run on the system clock.
*/
`timescale 1ns/1ns
interface smc_line_if;
   logic scl;
   logic sda;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   modport mon (output scl, output sda, output scl_fall, output start_det,
      output stop_det);
   modport core (input scl, input sda, input scl_fall, input start_det,
      input stop_det);
endinterface

// file: common/smc_pkg.sv
/*
 Constants, register layout and state encoding of the serial bus
 configuration and timing block.
 Assumes one system clock and registers reached over an Avalon-MM slave.
*/
// Operation
// - Master bit rate is about one third of the selected overflow rate.
// - Master SCL high lasts two overflow periods, low lasts one.
// - SCL is never driven high or low for less than one overflow period.
// - SCL phases are timed from the sampled bus level, stretching allowed.
// - Normal hold is at least 3 clocks; setup 1 clock plus software delay.
// - Extended hold keeps SDA 11 clocks before rise, 12 after fall.
// - Software delay runs from data write until the stall flag clears.
// - With low timeout enabled, timer reloads while SCL high, counts low.
// - Bus is free after SCL and SDA stay high over 10 overflow periods.
// - Enable is bit 7; when set pins are monitored, else inactive.
// - Slave inhibit, bit 6, masks slave interrupts; master ones remain.
// - Busy, bit 5, is set during a transfer, cleared by STOP or free.
// - Clock source select: 00 t0, 01 t1, 10 t2 high, 11 t2 low.
// - A pending master START is generated right after the free timeout.
// - In split mode only the timer high byte is held in reload.
// - One overflow period is the least SCL low time; two are the least high time.
package smc_pkg;

   ////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] SMC_CFG_IDX = 8'hC1;
   localparam logic [7:0] SMC_CTRL_IDX = 8'hC2;
   localparam logic [7:0] SMC_STAT_IDX = 8'hC3;
   localparam logic [7:0] SMC_MASK_IDX = 8'hC4;
   localparam logic [7:0] SMC_CFG_RST = 8'h00;
   localparam logic [7:0] SMC_CTRL_RST = 8'h04;
   localparam logic [3:0] SMC_STAT_RST = 4'h0;
   localparam logic [3:0] SMC_MASK_RST = 4'h0;

   // Configuration fields
   localparam int SMC_EN_BIT = 7;
   localparam int SMC_INH_BIT = 6;
   localparam int SMC_BUSY_BIT = 5;
   localparam int SMC_EXTH_BIT = 4;
   localparam int SMC_TOE_BIT = 3;
   localparam int SMC_FTE_BIT = 2;
   localparam int SMC_CS_LSB = 0;

   // Control fields
   localparam int SMC_START_BIT = 0;
   localparam int SMC_STOP_BIT = 1;
   localparam int SMC_SDA_BIT = 2;
   localparam int SMC_REL_BIT = 3;
   localparam int SMC_STALL_BIT = 4;

   // Status and mask fields
   localparam int SMC_ST_MDONE = 0;
   localparam int SMC_ST_SSTART = 1;
   localparam int SMC_ST_SSTOP = 2;
   localparam int SMC_ST_FREE = 3;

   ////////////////////////////////////////////////////////////////////////
   // Timing in overflow periods and system clocks
   localparam logic [3:0] SMC_LOW_OVF = 4'h1;
   localparam logic [3:0] SMC_HIGH_OVF = 4'h2;
   localparam logic [3:0] SMC_FREE_OVF = 4'hA;
   localparam logic [3:0] SMC_HOLD_STD = 4'h3;
   localparam logic [3:0] SMC_HOLD_EXT = 4'hC;
   localparam logic [3:0] SMC_SETUP_STD = 4'h1;
   localparam logic [3:0] SMC_SETUP_EXT = 4'hB;

   typedef enum logic [2:0] {
      SMC_IDLE = 3'b000,
      SMC_START = 3'b001,
      SMC_LOW = 3'b010,
      SMC_HIGH = 3'b011,
      SMC_STOP = 3'b100
   } smc_state_e;

endpackage

// file: hw/smc_line_mon.sv
/*
 Line monitor: two-flop synchronisers on SCL and SDA, then edge,
 START and STOP detection.
 Assumes pins are asynchronous to the system clock.
*/
`timescale 1ns/1ns
module smc_line_mon
   import smc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_enable,
   input wire logic i_scl_in,
   input wire logic i_sda_in,
   smc_line_if.mon line
);

   logic [1:0] meta_r;
   logic [1:0] sync_r;
   logic [1:0] prev_r;

   ////////////////////////////////////////////////////////////////////////
   // Index 1 is SCL, 0 is SDA; released bus idles high
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         meta_r <= 2'h3;
         sync_r <= 2'h3;
         prev_r <= 2'h3;
      end else begin
         meta_r <= {i_scl_in, i_sda_in};
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conditions only while enabled
   wire scl_steady_hi = sync_r[1] & prev_r[1];
   wire sda_fell = prev_r[0] & ~sync_r[0];
   wire sda_rose = ~prev_r[0] & sync_r[0];

   assign line.scl = sync_r[1];
   assign line.sda = sync_r[0];
   assign line.scl_fall = i_enable & prev_r[1] & ~sync_r[1];
   assign line.start_det = i_enable & scl_steady_hi & sda_fell;
   assign line.stop_det = i_enable & scl_steady_hi & sda_rose;

endmodule

// file: hw/smc_timing.sv
/*
 Serial bus configuration and timing core: master SCL generation,
 SDA setup and hold, SCL low timeout timer control, bus free timeout,
 busy flag, slave inhibit, interrupts and the Avalon-MM register slave.
 Assumes overflow inputs are one-clock pulses from same-clock timers and
 that the byte shifter and ACK logic sit outside.
*/
`timescale 1ns/1ns
module smc_timing
   import smc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [3:0] i_ovf,
   input wire logic i_tmo_split,
   output logic o_tmo_reload_hi,
   output logic o_tmo_reload_lo,
   output logic o_tmo_count_en,
   input wire logic i_scl_in,
   output logic o_scl_out,
   output logic o_scl_oe_n,
   input wire logic i_sda_in,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   output logic o_iface_enable,
   output logic o_slave_inhibit,
   output logic o_busy,
   output logic o_irq
);

   smc_line_if line ();

   smc_line_mon u_mon (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_enable(o_iface_enable),
      .i_scl_in(i_scl_in),
      .i_sda_in(i_sda_in),
      .line(line.mon)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0] cfg_r;
   logic start_req_r;
   logic stop_req_r;
   logic sda_val_r;
   logic stall_r;
   logic [3:0] stat_r;
   logic [3:0] mask_r;
   logic busy_r;
   logic own_r; // Our own STOP is seen late, after the master is idle
   logic inh_eff_r;
   logic acc_r;
   logic [7:0] rdata_r;

   // Master state
   smc_state_e state_r;
   smc_state_e state_nxt;
   logic [3:0] ovf_cnt_r;
   logic [3:0] ovf_cnt_nxt;
   logic [3:0] free_cnt_r;
   logic [3:0] hold_cnt_r;
   logic [3:0] setup_cnt_r;
   logic sda_drv_r;
   logic sda_drv_nxt;
   logic bit_done;
   logic gen_start;
   logic stop_done;

   ////////////////////////////////////////////////////////////////////////
   // Configuration decode
   wire en = cfg_r[SMC_EN_BIT];
   wire extended_hold = cfg_r[SMC_EXTH_BIT];
   wire [1:0] cs = cfg_r[SMC_CS_LSB +: 2];
   wire ovf = i_ovf[cs];
   wire [3:0] hold_min = extended_hold ? SMC_HOLD_EXT : SMC_HOLD_STD;
   wire [3:0] setup_min = extended_hold ? SMC_SETUP_EXT : SMC_SETUP_STD;
   wire hold_ok = hold_cnt_r >= hold_min;
   wire setup_ok = setup_cnt_r >= setup_min;
   wire master = (state_r != SMC_IDLE) | own_r;

   assign o_iface_enable = en;
   assign o_slave_inhibit = inh_eff_r;
   assign o_busy = busy_r;

   ////////////////////////////////////////////////////////////////////////
   // Avalon slave: answer one cycle after the request appears
   wire req = i_avs_read | i_avs_write;
   wire [7:0] idx = i_avs_address[9:2];
   wire wr_en = i_avs_write & acc_r;
   wire rd_en = i_avs_read & acc_r;
   wire wr_cfg = wr_en & (idx == SMC_CFG_IDX);
   wire wr_ctrl = wr_en & (idx == SMC_CTRL_IDX);
   wire wr_mask = wr_en & (idx == SMC_MASK_IDX);
   wire rd_stat = rd_en & (idx == SMC_STAT_IDX);
   wire [7:0] wd = i_avs_writedata[7:0];

   assign o_avs_waitrequest = req & ~acc_r;
   assign o_avs_readdata = {24'h000000, rdata_r};

   wire [7:0] cfg_view = {cfg_r[7:6], busy_r, cfg_r[4:0]};
   wire [7:0] ctrl_view = {3'h0, stall_r, 1'b0, sda_val_r, stop_req_r,
      start_req_r};
   wire [7:0] rd_mux =
      (idx == SMC_CFG_IDX) ? cfg_view :
      (idx == SMC_CTRL_IDX) ? ctrl_view :
      (idx == SMC_STAT_IDX) ? {4'h0, stat_r} :
      (idx == SMC_MASK_IDX) ? {4'h0, mask_r} : 8'h00;

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         acc_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         acc_r <= req & ~acc_r;
         if (i_avs_read & ~acc_r) begin
            rdata_r <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration and mask registers
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         cfg_r <= SMC_CFG_RST;
         mask_r <= SMC_MASK_RST;
      end else begin
         if (wr_cfg) begin
            cfg_r <= {wd[7:6], 1'b0, wd[4:0]};
         end
         if (wr_mask) begin
            mask_r <= wd[3:0];
         end
      end
   end

   // Request bits leave with the condition they asked for
   always_ff @(posedge i_clock) begin
      if (!i_reset_n || !en) begin
         start_req_r <= 1'b0;
         stop_req_r <= 1'b0;
         sda_val_r <= SMC_CTRL_RST[SMC_SDA_BIT];
      end else begin
         if (wr_ctrl) begin
            sda_val_r <= wd[SMC_SDA_BIT];
         end
         if (wr_ctrl && wd[SMC_START_BIT]) begin
            start_req_r <= 1'b1;
         end else if (gen_start) begin
            start_req_r <= 1'b0;
         end
         if (wr_ctrl && wd[SMC_STOP_BIT]) begin
            stop_req_r <= 1'b1;
         end else if (stop_done) begin
            stop_req_r <= 1'b0;
         end
      end
   end

   // Stall flag holds SCL low; setting wins over release
   always_ff @(posedge i_clock) begin
      if (!i_reset_n || !en) begin
         stall_r <= 1'b0;
      end else if (bit_done) begin
         stall_r <= 1'b1;
      end else if (wr_ctrl && wd[SMC_REL_BIT]) begin
         stall_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Busy, free timeout and slave inhibit
   wire both_high = line.scl & line.sda;
   wire free_to = en & cfg_r[SMC_FTE_BIT] & both_high & ovf
      & (free_cnt_r == SMC_FREE_OVF);
   wire slave_start = line.start_det & ~master;
   wire slave_stop = line.stop_det & ~master;

   always_ff @(posedge i_clock) begin
      if (!i_reset_n || !en) begin
         free_cnt_r <= 4'h0;
      end else if (!both_high || !busy_r) begin
         free_cnt_r <= 4'h0;
      end else if (ovf && free_cnt_r != SMC_FREE_OVF) begin
         free_cnt_r <= free_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_reset_n || !en) begin
         busy_r <= 1'b0;
         own_r <= 1'b0;
      end else if (line.start_det || gen_start) begin
         busy_r <= 1'b1;
         own_r <= own_r | gen_start;
      end else if (line.stop_det || free_to) begin
         busy_r <= 1'b0;
         own_r <= 1'b0;
      end
   end

   // Inhibit takes hold at the next START so a transfer is not cut short
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         inh_eff_r <= 1'b0;
      end else if (line.start_det || !cfg_r[SMC_INH_BIT]) begin
         inh_eff_r <= cfg_r[SMC_INH_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read clears only the bits it returned; new events win
   wire [3:0] ev;
   assign ev[SMC_ST_MDONE] = bit_done;
   assign ev[SMC_ST_SSTART] = slave_start & ~inh_eff_r;
   assign ev[SMC_ST_SSTOP] = slave_stop & ~inh_eff_r;
   assign ev[SMC_ST_FREE] = free_to;

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         stat_r <= SMC_STAT_RST;
      end else begin
         stat_r <= (rd_stat ? stat_r & ~rdata_r[3:0] : stat_r) | ev;
      end
   end

   assign o_irq = |(stat_r & mask_r);

   ////////////////////////////////////////////////////////////////////////
   // SCL low timeout timer control
   wire toe = en & cfg_r[SMC_TOE_BIT];
   assign o_tmo_reload_hi = toe & line.scl;
   assign o_tmo_reload_lo = toe & line.scl & ~i_tmo_split;
   assign o_tmo_count_en = toe & ~line.scl;

   ////////////////////////////////////////////////////////////////////////
   // Master SCL generator
   always_comb begin
      state_nxt = state_r;
      ovf_cnt_nxt = ovf_cnt_r;
      bit_done = 1'b0;
      gen_start = 1'b0;
      stop_done = 1'b0;
      unique case (state_r)
         SMC_IDLE: begin
            ovf_cnt_nxt = 4'h0;
            // Free timeout clears busy, so a pending START follows at once
            if (start_req_r && !busy_r && both_high) begin
               state_nxt = SMC_START;
               gen_start = 1'b1;
            end
         end
         SMC_START: begin
            if (ovf) begin
               ovf_cnt_nxt = ovf_cnt_r + 4'h1;
            end
            if (ovf_cnt_r >= SMC_HIGH_OVF) begin
               state_nxt = SMC_LOW;
               ovf_cnt_nxt = 4'h0;
            end
         end
         SMC_LOW: begin
            // Count only while the bus is really low
            if (ovf && !line.scl && ovf_cnt_r < SMC_LOW_OVF) begin
               ovf_cnt_nxt = ovf_cnt_r + 4'h1;
            end
            if (ovf_cnt_r >= SMC_LOW_OVF && !stall_r && setup_ok) begin
               ovf_cnt_nxt = 4'h0;
               state_nxt = stop_req_r ? SMC_STOP : SMC_HIGH;
            end
         end
         SMC_HIGH: begin
            if (!line.scl && ovf_cnt_r != 4'h0) begin
               // Another master pulled SCL low: restart the low phase
               state_nxt = SMC_LOW;
               ovf_cnt_nxt = 4'h0;
            end else if (ovf_cnt_r >= SMC_HIGH_OVF) begin
               state_nxt = SMC_LOW;
               ovf_cnt_nxt = 4'h0;
               bit_done = 1'b1;
            end else if (ovf && line.scl) begin
               ovf_cnt_nxt = ovf_cnt_r + 4'h1;
            end
         end
         SMC_STOP: begin
            if (ovf && line.scl) begin
               ovf_cnt_nxt = ovf_cnt_r + 4'h1;
            end
            if (ovf_cnt_r >= SMC_LOW_OVF) begin
               state_nxt = SMC_IDLE;
               stop_done = 1'b1;
            end
         end
         default: begin
            state_nxt = SMC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_reset_n || !en) begin
         state_r <= SMC_IDLE;
         ovf_cnt_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         ovf_cnt_r <= ovf_cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // SDA setup and hold around master SCL edges
   wire scl_low_phase = (state_r == SMC_LOW);
   wire sda_want = (state_r == SMC_START || state_r == SMC_STOP)
      ? 1'b0 : sda_val_r;

   always_comb begin
      sda_drv_nxt = sda_drv_r;
      if (state_r == SMC_IDLE) begin
         sda_drv_nxt = 1'b1;
      end else if (state_r == SMC_START) begin
         sda_drv_nxt = 1'b0;
      end else if (state_r == SMC_STOP) begin
         sda_drv_nxt = stop_done;
      end else if (scl_low_phase && hold_ok) begin
         sda_drv_nxt = stop_req_r ? 1'b0 : sda_want;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_reset_n || !en) begin
         sda_drv_r <= 1'b1;
         hold_cnt_r <= 4'h0;
         setup_cnt_r <= 4'h0;
      end else begin
         sda_drv_r <= sda_drv_nxt;
         if (state_r != SMC_LOW) begin
            hold_cnt_r <= 4'h0;
         end else if (!hold_ok) begin
            hold_cnt_r <= hold_cnt_r + 4'h1;
         end
         if (sda_drv_nxt != sda_drv_r || !hold_ok) begin
            setup_cnt_r <= 4'h0;
         end else if (!setup_ok) begin
            setup_cnt_r <= setup_cnt_r + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Open-drain pins: enable low means this end pulls the line low
   assign o_scl_out = 1'b0;
   assign o_sda_out = 1'b0;
   assign o_scl_oe_n = ~(scl_low_phase & en);
   assign o_sda_oe_n = sda_drv_r | ~en;

endmodule
